// >>> bso_cfg.svh
`ifndef BSO_CFG_SVH
`define BSO_CFG_SVH

// register byte offsets
`define BSO_OFS_CTRL 5'h00
`define BSO_OFS_SPD_THR 5'h04
`define BSO_OFS_WAIT 5'h08
`define BSO_OFS_STOP 5'h0C
`define BSO_OFS_WARN 5'h10
`define BSO_OFS_DERATE 5'h14
`define BSO_OFS_STATUS 5'h18
`define BSO_OFS_OVL_ACC 5'h1C

// control register bits
`define BSO_CTRL_SERVO_ON 0
`define BSO_CTRL_ALM_CLR 1
`define BSO_CTRL_RESTART 2

// status register bits
`define BSO_ST_BRAKE_REL 0
`define BSO_ST_POWER 1
`define BSO_ST_ZERO_REF 2
`define BSO_ST_WARN 3
`define BSO_ST_ALM_COAST 4
`define BSO_ST_ALM_SEL 5
`define BSO_ST_STATE_LO 8
`define BSO_ST_G2_COAST 10
`define BSO_ST_DERATE_LO 16

// setting ranges and reset values
`define BSO_SPD_THR_MIN 16'h0000
`define BSO_SPD_THR_MAX 16'h2710
`define BSO_SPD_THR_DEF 16'h0064
`define BSO_WAIT_MIN 8'h0A
`define BSO_WAIT_MAX 8'h64
`define BSO_WAIT_DEF 8'h32
`define BSO_WARN_MIN 8'h01
`define BSO_WARN_MAX 8'h64
`define BSO_WARN_DEF 8'h14
`define BSO_DER_MIN 8'h0A
`define BSO_DER_MAX 8'h64
`define BSO_DER_DEF 8'h64
`define BSO_G2_SEL_DEF 1'b0

// timing: 10 ms ticks at 125 MHz
`define BSO_TICK_MS 10
`define BSO_CLK_KHZ 125000
`define BSO_TICK_CYCLES (`BSO_TICK_MS * `BSO_CLK_KHZ)

// overload model
`define BSO_PCT_FULL 24'h000064
`define BSO_OVL_LIMIT 32'h000F4240
`define BSO_OVL_DECAY 32'h00000064
`define BSO_HI_PCT 24'h00012C
`define BSO_HI_TICKS 8'h0A
`define BSO_ZERO_SPEED 16'h0014

`endif

// >>> bso_pkg.sv
package bso_pkg;

  // supervisory states, gray along idle-run-zero stop-coast
  typedef enum logic [1:0] {
    BSO_IDLE = 2'h0,
    BSO_RUN = 2'h1,
    BSO_ZSTOP = 2'h3,
    BSO_COAST = 2'h2
  } bso_state_t;

  // control loop mode from the drive
  typedef enum logic [1:0] {
    BSO_MODE_POS = 2'h0,
    BSO_MODE_SPD = 2'h1,
    BSO_MODE_TRQ = 2'h2
  } bso_mode_t;

  // live settings and pending settings (derate_pend, g2_sel_pend)
  typedef struct packed {
    logic [15:0] spd_thr;
    logic [7:0] wait_t;
    logic [7:0] warn_pct;
    logic [7:0] derate_pend;
    logic g2_sel_pend;
  } bso_cfg_t;

endpackage : bso_pkg

// >>> bso_tick.sv
`timescale 1ns/10ps
`default_nettype none
`include "bso_cfg.svh"

module bso_tick
  import bso_pkg::*;
#(
  parameter int TICK_CYCLES = `BSO_TICK_CYCLES
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic restart,
  // tick out
  output logic tick
);

  logic [20:0] cnt_q;
  logic [20:0] cnt_d;
  logic wrap;
  logic tick_q;

  // wrap detect; restart realigns the phase to the event
  assign wrap = (cnt_q == 21'(TICK_CYCLES - 1));
  assign cnt_d = (restart || wrap) ? 21'h000000 : cnt_q + 21'h000001;
  assign tick = tick_q;

  // prescaler
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt_q <= 21'h000000;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= wrap && !restart;
    end
  end

endmodule : bso_tick

`default_nettype wire

// >>> bso_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "bso_cfg.svh"

module bso_ctrl
  import bso_pkg::*;
#(
  parameter int TICK_CYCLES = `BSO_TICK_CYCLES
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // motor feedback
  input wire logic signed [15:0] motor_speed,
  input wire logic [15:0] motor_max_speed,
  input wire logic [15:0] motor_current,
  input wire logic [15:0] base_current,
  input wire logic [1:0] control_mode,
  // alarm sources
  input wire logic coast_alarm_group,
  input wire logic selectable_alarm_group,
  // drive outputs
  output logic brake_release_output,
  output logic motor_power_on,
  output logic speed_ref_zero,
  output logic warn_output,
  output logic alarm_active
);

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge_be = (old_v & ~m) | (new_v & m);
  endfunction : merge_be

  // clamp a setting into its legal range
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp16

  bso_state_t state_q, state_d;
  bso_cfg_t cfg_q;
  logic servo_on_q, ack_q, g2_coast_q, alm_c_q, alm_s_q;
  logic [7:0] derate_q, wait_cnt_q, hi_cnt_q;
  logic [31:0] acc_q, readdata_q;
  logic brake_q, power_q, zero_q, warn_q;
  logic tick, tick_restart;

  // bus strobes: one wait state per access
  logic req, wr_en, rd_load;
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_q;
  assign wr_en = avs_write && ack_q;
  assign rd_load = avs_read && !ack_q;

  // address decode
  logic hit_ctrl, hit_thr, hit_wait, hit_stop, hit_warn, hit_der;
  assign hit_ctrl = (avs_address[4:2] == `BSO_OFS_CTRL >> 2);
  assign hit_thr = (avs_address[4:2] == `BSO_OFS_SPD_THR >> 2);
  assign hit_wait = (avs_address[4:2] == `BSO_OFS_WAIT >> 2);
  assign hit_stop = (avs_address[4:2] == `BSO_OFS_STOP >> 2);
  assign hit_warn = (avs_address[4:2] == `BSO_OFS_WARN >> 2);
  assign hit_der = (avs_address[4:2] == `BSO_OFS_DERATE >> 2);

  // status word
  logic [31:0] status_w;
  assign status_w = {8'h00, derate_q, 5'h00, g2_coast_q, state_q, 2'h0, alm_s_q, alm_c_q,
                     warn_q, zero_q, power_q, brake_q};

  // read mux; all eight word offsets are mapped, address bits 1:0 ignored
  logic [31:0] rd_mux;
  assign rd_mux =
    hit_ctrl ? {31'h00000000, servo_on_q} :
    hit_thr ? {16'h0000, cfg_q.spd_thr} :
    hit_wait ? {24'h000000, cfg_q.wait_t} :
    hit_stop ? {31'h00000000, cfg_q.g2_sel_pend} :
    hit_warn ? {24'h000000, cfg_q.warn_pct} :
    hit_der ? {24'h000000, cfg_q.derate_pend} :
    (avs_address[4:2] == `BSO_OFS_STATUS >> 2) ? status_w :
    (avs_address[4:2] == `BSO_OFS_OVL_ACC >> 2) ? acc_q : 32'h00000000;
  assign avs_readdata = readdata_q;

  // merged write values, clamped to the legal ranges
  logic [31:0] wv;
  logic [15:0] thr_w;
  logic [7:0] wait_w, warn_w, der_w;
  assign wv = merge_be(rd_mux, avs_writedata, avs_byteenable);
  assign thr_w = clamp16(wv[15:0], `BSO_SPD_THR_MIN, `BSO_SPD_THR_MAX);
  assign wait_w = 8'(clamp16({8'h00, wv[7:0]}, {8'h00, `BSO_WAIT_MIN},
                             {8'h00, `BSO_WAIT_MAX}));
  assign warn_w = 8'(clamp16({8'h00, wv[7:0]}, {8'h00, `BSO_WARN_MIN},
                             {8'h00, `BSO_WARN_MAX}));
  assign der_w = 8'(clamp16({8'h00, wv[7:0]}, {8'h00, `BSO_DER_MIN}, {8'h00, `BSO_DER_MAX}));

  // control strobes
  logic servo_off_command, alm_clr, soft_restart;
  assign servo_off_command = wr_en && hit_ctrl && !wv[`BSO_CTRL_SERVO_ON];
  assign alm_clr = wr_en && hit_ctrl && wv[`BSO_CTRL_ALM_CLR];
  assign soft_restart = wr_en && hit_ctrl && wv[`BSO_CTRL_RESTART];

  // speed compare
  logic [15:0] speed_abs, thr_eff;
  logic below_thr, stopped;
  assign speed_abs = motor_speed[15] ? 16'(-motor_speed) : 16'(motor_speed);
  // threshold limited to motor maximum speed
  assign thr_eff = (cfg_q.spd_thr > motor_max_speed) ? motor_max_speed : cfg_q.spd_thr;
  assign below_thr = speed_abs < thr_eff;
  assign stopped = speed_abs < `BSO_ZERO_SPEED;

  // overload arithmetic, scaled by 100 to avoid dividing
  logic [23:0] cur_x100, der_lvl, hi_lvl, excess;
  logic over_base, over_hi, ovl_alarm, warn_cond;
  logic [39:0] acc_x100, warn_lvl;
  logic [31:0] acc_d;
  assign cur_x100 = 24'(motor_current) * `BSO_PCT_FULL;
  // accumulate only above derated base current
  assign der_lvl = 24'(base_current) * 24'(derate_q);
  assign over_base = cur_x100 > der_lvl;
  assign excess = cur_x100 - der_lvl;
  // high-load level uses base current and a fixed percentage, not the derating
  assign hi_lvl = 24'(base_current) * `BSO_HI_PCT;
  assign over_hi = cur_x100 > hi_lvl;
  assign ovl_alarm = acc_q >= `BSO_OVL_LIMIT;
  // warning scales the same accumulator as the alarm
  assign acc_x100 = 40'(acc_q) * 40'(`BSO_PCT_FULL);
  assign warn_lvl = 40'(`BSO_OVL_LIMIT) * 40'(cfg_q.warn_pct);
  // warning at set fraction of alarm time
  assign warn_cond = acc_x100 >= warn_lvl;
  assign acc_d =
    !tick ? acc_q :
    over_base ? (ovl_alarm ? acc_q : acc_q + 32'(excess)) :
    (acc_q > `BSO_OVL_DECAY) ? acc_q - `BSO_OVL_DECAY : 32'h00000000;

  // alarm sources, latched; set wins over clear
  logic alm_c_set, alm_s_set, alarm_any;
  // fixed high-load alarm into the coast group
  assign alm_c_set = coast_alarm_group || (tick && over_hi && hi_cnt_q == `BSO_HI_TICKS - 8'h01);
  assign alm_s_set = selectable_alarm_group || ovl_alarm;
  assign alarm_any = alm_c_q || alm_s_q;

  // stop method selection
  logic pos_spd, zero_stop_sel;
  // selection honoured in position and speed modes only
  assign pos_spd = (control_mode == BSO_MODE_POS) || (control_mode == BSO_MODE_SPD);
  // restart-latched selection; 0 picks zero-speed stop
  assign zero_stop_sel = alm_s_q && !g2_coast_q && pos_spd;

  // wait timer
  logic wait_done;
  // live wait setting ends the coast window
  assign wait_done = wait_cnt_q >= cfg_q.wait_t;

  // next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      BSO_IDLE:
        if (servo_on_q && !alarm_any)
          state_d = BSO_RUN;
      BSO_RUN:
        // coast group wins over any selection
        if (alm_c_q)
          state_d = BSO_COAST;
        // zero stop first: an alarm also clears servo-on
        else if (zero_stop_sel)
          state_d = BSO_ZSTOP;
        else if (alm_s_q || !servo_on_q)
          state_d = BSO_COAST;
      BSO_ZSTOP:
        // once stopped, power goes off and the brake drops
        if (alm_c_q)
          state_d = BSO_COAST;
        else if (stopped)
          state_d = BSO_IDLE;
      BSO_COAST:
        // speed threshold or timeout engages the brake
        if (below_thr || wait_done)
          state_d = BSO_IDLE;
    endcase
  end

  // timer phase starts at power removal
  assign tick_restart = (state_d == BSO_COAST) && (state_q != BSO_COAST);

  bso_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .restart(tick_restart),
    .tick(tick)
  );

  // bus handshake and read data
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      readdata_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= req && !ack_q;
      readdata_q <= rd_load ? rd_mux : readdata_q;
    end
  end

  // settings; live ones act at once, pending ones at restart
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cfg_q <= '{`BSO_SPD_THR_DEF, `BSO_WAIT_DEF, `BSO_WARN_DEF, `BSO_DER_DEF, `BSO_G2_SEL_DEF};
      derate_q <= `BSO_DER_DEF;
      g2_coast_q <= `BSO_G2_SEL_DEF;
    end
    else
    begin
      if (wr_en && hit_thr)
        cfg_q.spd_thr <= thr_w;
      if (wr_en && hit_wait)
        cfg_q.wait_t <= wait_w;
      if (wr_en && hit_warn)
        cfg_q.warn_pct <= warn_w;
      if (wr_en && hit_der)
        cfg_q.derate_pend <= der_w;
      if (wr_en && hit_stop)
        cfg_q.g2_sel_pend <= wv[0];
      // pending stop select copied only on restart
      if (soft_restart)
      begin
        derate_q <= cfg_q.derate_pend;
        g2_coast_q <= cfg_q.g2_sel_pend;
      end
    end
  end

  // servo enable and alarm latches
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      servo_on_q <= 1'b0;
      alm_c_q <= 1'b0;
      alm_s_q <= 1'b0;
    end
    else
    begin
      // an alarm withdraws the servo-on request
      if (alarm_any || alm_c_set || alm_s_set)
        servo_on_q <= 1'b0;
      else if (wr_en && hit_ctrl)
        servo_on_q <= wv[`BSO_CTRL_SERVO_ON];
      alm_c_q <= alm_c_set || (alm_c_q && !alm_clr);
      alm_s_q <= alm_s_set || (alm_s_q && !alm_clr);
    end
  end

  // state, timers and overload accumulator
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_q <= BSO_IDLE;
      wait_cnt_q <= 8'h00;
      hi_cnt_q <= 8'h00;
      acc_q <= 32'h00000000;
    end
    else
    begin
      state_q <= state_d;
      // held at zero outside coast, so a lowered wait setting never meets a stale count
      wait_cnt_q <= (tick_restart || state_d != BSO_COAST) ? 8'h00 :
                    wait_cnt_q + 8'(tick && !wait_done);
      hi_cnt_q <= !tick ? hi_cnt_q : (over_hi && !alm_c_q) ? hi_cnt_q + 8'h01 : 8'h00;
      acc_q <= acc_d;
    end
  end

  // registered drive outputs
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      brake_q <= 1'b0;
      power_q <= 1'b0;
      zero_q <= 1'b0;
      warn_q <= 1'b0;
    end
    else
    begin
      // brake released whenever the motor is powered
      brake_q <= state_d != BSO_IDLE;
      power_q <= (state_d == BSO_RUN) || (state_d == BSO_ZSTOP);
      // zero reference only during zero-speed stop
      zero_q <= state_d == BSO_ZSTOP;
      warn_q <= warn_cond;
    end
  end

  assign brake_release_output = brake_q;
  assign motor_power_on = power_q;
  assign speed_ref_zero = zero_q;
  assign warn_output = warn_q;
  assign alarm_active = alm_c_q || alm_s_q;

  // checks
  a_brake_speed: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == BSO_COAST && below_thr) |=> !brake_release_output)
    else $error("brake not engaged below threshold");
  a_brake_timeout: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == BSO_COAST && wait_done) |=> !brake_release_output)
    else $error("brake not engaged after wait");
  a_thr_range: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_q.spd_thr <= `BSO_SPD_THR_MAX)
    else $error("threshold out of range");
  a_wait_range: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_q.wait_t >= `BSO_WAIT_MIN && cfg_q.wait_t <= `BSO_WAIT_MAX
    && wait_cnt_q <= cfg_q.wait_t)
    else $error("wait setting or timer out of range");
  a_alarm_power: assert property (@(posedge mclk) disable iff (!rst_n)
    (alarm_any && state_q == BSO_RUN && !zero_stop_sel) |=> ##1 !motor_power_on)
    else $error("power kept after alarm");
  a_servo_coast: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == BSO_RUN && !servo_on_q && !alarm_any) |=> (state_q == BSO_COAST) ##0
    (!motor_power_on && !speed_ref_zero))
    else $error("servo-off did not coast");
  a_group1_coast: assert property (@(posedge mclk) disable iff (!rst_n)
    (alm_c_q && state_q != BSO_IDLE) |=> state_q inside {BSO_COAST, BSO_IDLE})
    else $error("coast group alarm not coasting");
  a_torque_coast: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == BSO_RUN && alm_s_q && control_mode == BSO_MODE_TRQ) |=> state_q == BSO_COAST)
    else $error("torque mode did not coast");
  a_zero_cause: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(speed_ref_zero) |-> $past(alm_s_q) && !$past(g2_coast_q))
    else $error("zero reference without cause");
  a_warn_before: assert property (@(posedge mclk) disable iff (!rst_n)
    ovl_alarm |-> ##1 warn_output)
    else $error("alarm level without warning");
  a_power_brake: assert property (@(posedge mclk) disable iff (!rst_n)
    motor_power_on |-> brake_release_output)
    else $error("brake applied while powered");

endmodule : bso_ctrl

`default_nettype wire

// >>> bso_motor_model.sv
`timescale 1ns/10ps
`default_nettype none

module bso_motor_model
  import bso_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // host side stimulus
  input wire logic signed [15:0] cmd_speed,
  input wire logic [15:0] coast_step,
  // amplifier outputs
  input wire logic motor_power_on,
  input wire logic speed_ref_zero,
  input wire logic brake_release_output,
  // shaft feedback
  output logic signed [15:0] motor_speed
);
  logic signed [15:0] spd_q;
  logic signed [15:0] spd_d;
  logic signed [15:0] step;
  logic signed [15:0] mag;

  // forced zero reference decelerates hard; friction alone may be zero
  assign step = speed_ref_zero ? 16'sh0010 : $signed(coast_step);
  assign mag = (spd_q < 0) ? -spd_q : spd_q;
  // separate brake line
  // the relay is wired on its own line, so falling speed never holds it open
  // a powered zero-speed stop decelerates instead of following the command
  assign spd_d = (motor_power_on && !speed_ref_zero) ? cmd_speed :
                 !brake_release_output ? 16'sh0000 :
                 (mag <= step) ? 16'sh0000 :
                 (spd_q < 0) ? spd_q + step : spd_q - step;

  // shaft state, an applied brake stops it at once
  always_ff @(posedge mclk)
    if (!rst_n)
      spd_q <= 16'sh0000;
    else
      spd_q <= spd_d;

  assign motor_speed = spd_q;
endmodule : bso_motor_model

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "bso_cfg.svh"

module tb_top
  import bso_pkg::*;
;
  // short tick keeps the run brief
  localparam int TCK = 20;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic signed [15:0] motor_speed;
  logic [15:0] motor_max_speed = 16'h0BB8;
  logic [15:0] motor_current = 16'h0000;
  logic [15:0] base_current = 16'h0064;
  logic [1:0] control_mode = 2'h0;
  logic coast_alarm_group = 1'b0;
  logic selectable_alarm_group = 1'b0;
  logic brake_release_output, motor_power_on, speed_ref_zero, warn_output, alarm_active;
  logic signed [15:0] cmd_speed = 16'sh0000;
  logic [15:0] coast_step = 16'h0000;
  int errors = 0;
  int comparisons = 0;

  // 125 MHz
  always #4 mclk = ~mclk;

  bso_ctrl #(.TICK_CYCLES(TCK)) uut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .motor_speed(motor_speed), .motor_max_speed(motor_max_speed),
    .motor_current(motor_current), .base_current(base_current), .control_mode(control_mode),
    .coast_alarm_group(coast_alarm_group), .selectable_alarm_group(selectable_alarm_group),
    .brake_release_output(brake_release_output), .motor_power_on(motor_power_on),
    .speed_ref_zero(speed_ref_zero), .warn_output(warn_output), .alarm_active(alarm_active));

  bso_motor_model motor (.mclk(mclk), .rst_n(rst_n), .cmd_speed(cmd_speed),
    .coast_step(coast_step), .motor_power_on(motor_power_on), .speed_ref_zero(speed_ref_zero),
    .brake_release_output(brake_release_output), .motor_speed(motor_speed));

  task automatic complete_run();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one avalon access, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 40)
    begin
      errors++;
      complete_run();
    end
    @(posedge mclk);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rd_chk

  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask : reset_dut

  task automatic reg_case();
    rd_chk(`BSO_OFS_SPD_THR, 32'h64);
    rd_chk(`BSO_OFS_WAIT, 32'h32);
    rd_chk(`BSO_OFS_WARN, 32'h14);
    rd_chk(`BSO_OFS_DERATE, 32'h64);
    rd_chk(`BSO_OFS_STOP, 32'h0);
    rd_chk(`BSO_OFS_STATUS, 32'h00640000);
    wr(`BSO_OFS_SPD_THR, 32'hFFFF);
    rd_chk(`BSO_OFS_SPD_THR, 32'h2710);
    wr(`BSO_OFS_WAIT, 32'h05);
    rd_chk(`BSO_OFS_WAIT, 32'h0A);
    wr(`BSO_OFS_WAIT, 32'hFF);
    rd_chk(`BSO_OFS_WAIT, 32'h64);
    wr(`BSO_OFS_WARN, 32'h00);
    rd_chk(`BSO_OFS_WARN, 32'h01);
    wr(`BSO_OFS_DERATE, 32'h05);
    rd_chk(`BSO_OFS_DERATE, 32'h0A);
  endtask : reg_case

  task automatic brake_case(input logic [15:0] thr, input logic [15:0] maxs,
                            input logic signed [15:0] spd, input logic [15:0] stp,
                            input logic [7:0] wt, input int lo, input int hi);
    int cnt;
    wr(`BSO_OFS_SPD_THR, {16'h0, thr});
    wr(`BSO_OFS_WAIT, {24'h0, wt});
    motor_max_speed <= maxs;
    cmd_speed <= spd;
    coast_step <= stp;
    wr(`BSO_OFS_CTRL, 32'h1);
    repeat (4) @(posedge mclk);
    check({30'h0, motor_power_on, brake_release_output}, 32'h3);
    wr(`BSO_OFS_CTRL, 32'h0);
    @(posedge mclk);
    check({30'h0, motor_power_on, speed_ref_zero}, 32'h0);
    cnt = 0;
    while (brake_release_output !== 1'b0 && cnt < 1500)
    begin
      @(posedge mclk);
      cnt++;
    end
    check({31'h0, cnt >= lo && cnt <= hi}, 32'h1);
  endtask : brake_case

  task automatic stop_case(input logic [1:0] mode, input logic sel, input logic rs,
                           input logic grp, input logic zero);
    int cnt;
    wr(`BSO_OFS_STOP, {31'h0, sel});
    if (rs)
      wr(`BSO_OFS_CTRL, 32'h4);
    control_mode <= mode;
    cmd_speed <= 16'sd500;
    coast_step <= 16'h0004;
    wr(`BSO_OFS_CTRL, 32'h1);
    repeat (4) @(posedge mclk);
    coast_alarm_group <= grp;
    selectable_alarm_group <= !grp;
    @(posedge mclk);
    coast_alarm_group <= 1'b0;
    selectable_alarm_group <= 1'b0;
    repeat (3) @(posedge mclk);
    check({alarm_active, motor_power_on, speed_ref_zero}, {1'b1, zero, zero});
    cnt = 0;
    while (brake_release_output !== 1'b0 && cnt < 400)
    begin
      @(posedge mclk);
      cnt++;
    end
    @(posedge mclk);
    check({brake_release_output, speed_ref_zero}, 32'h0);
    wr(`BSO_OFS_CTRL, 32'h2);
  endtask : stop_case

  // warning time as share of alarm time
  task automatic ovl_case(input int pct, input int der, input int cur);
    int add, n, cnt;
    reset_dut();
    wr(`BSO_OFS_WARN, pct);
    wr(`BSO_OFS_DERATE, der);
    wr(`BSO_OFS_CTRL, 32'h4);
    add = cur * 100 - 100 * der;
    n = (add > 0) ? (`BSO_OVL_LIMIT * pct + 100 * add - 1) / (100 * add) : 0;
    motor_current <= cur;
    cnt = 0;
    while (warn_output !== 1'b1 && cnt < 40 * TCK)
    begin
      @(posedge mclk);
      cnt++;
    end
    if (n == 0)
      check({31'h0, warn_output}, 32'h0);
    else
      check({31'h0, cnt >= (n - 1) * TCK && cnt <= n * TCK + 4}, 32'h1);
    motor_current <= 16'h0000;
  endtask : ovl_case

  // high-load alarm after ten ticks, whatever the derating
  task automatic hi_case();
    reset_dut();
    wr(`BSO_OFS_DERATE, 32'h0A);
    wr(`BSO_OFS_CTRL, 32'h4);
    motor_current <= 16'h0190;
    repeat (8 * TCK) @(posedge mclk);
    check({31'h0, alarm_active}, 32'h0);
    repeat (4 * TCK) @(posedge mclk);
    check({31'h0, alarm_active}, 32'h1);
    motor_current <= 16'h0000;
  endtask : hi_case

  initial
  begin
    reset_dut();
    reg_case();
    brake_case(16'h0064, 16'h0BB8, 16'sd500, 16'h1, 8'h32, 395, 410);
    brake_case(16'h2710, 16'h012C, -16'sd400, 16'h0, 8'h0A, 10 * TCK - 4, 10 * TCK + 6);
    brake_case(16'h2710, 16'h01F4, -16'sd400, 16'h0, 8'h0A, 0, 3);
    stop_case(BSO_MODE_POS, 1'b1, 1'b0, 1'b0, 1'b1);
    stop_case(BSO_MODE_POS, 1'b1, 1'b1, 1'b0, 1'b0);
    stop_case(BSO_MODE_SPD, 1'b0, 1'b1, 1'b0, 1'b1);
    stop_case(BSO_MODE_TRQ, 1'b0, 1'b0, 1'b0, 1'b0);
    stop_case(BSO_MODE_SPD, 1'b0, 1'b0, 1'b1, 1'b0);
    ovl_case(20, 100, 200);
    ovl_case(50, 50, 200);
    ovl_case(20, 100, 100);
    hi_case();
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
